// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsl_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
  import vsl_pkg::*;
  logic clk, rst_n, de, vs, hs, w24, lf, edge_sel, inv_n, error_test_entry, emph, swing;
  logic attach, lock, stall, hp_n, lock_n, rdy, valid, w24_o, train, bet_o;
  logic hold, swing_o, emph_o, drop;
  logic [9:0] r, g, b;
  logic [1:0] u, frange;
  logic [35:0] word, prev;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  vsl_link_ctrl DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_pix_red(r), .i_pix_green(g),
    .i_pix_blue(b), .i_user_bits(u), .i_de(de), .i_vsync(vs), .i_hsync(hs),
    .i_width_select(w24), .i_low_freq_select(lf), .i_latch_edge_select(edge_sel),
    .i_enable_invert_n(inv_n), .i_error_test_entry(error_test_entry), .i_emphasis_select(emph),
    .i_swing_select(swing), .i_hot_plug_n(hp_n), .i_rx_lock_n(lock_n), .i_word_ready(rdy),
    .o_word_valid(valid), .o_word(word), .o_freq_range(frange), .o_width24(w24_o),
    .o_send_training(train), .o_bet_active(bet_o), .o_serial_hold_high(hold),
    .o_swing_high(swing_o), .o_emphasis_en(emph_o), .o_drop_seen(drop));
  vsl_rx_model u_rx (.i_attach(attach), .i_lock(lock), .i_stall(stall),
    .o_hot_plug_n(hp_n), .o_rx_lock_n(lock_n), .o_word_ready(rdy));
  // 25 mhz pixel clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // all inputs change one ns after the rising edge
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // straps only load in reset, so a mode change always goes through it
  task automatic do_reset(input logic w, input logic l);
    rst_n = 1'b0;
    w24 = w;
    lf = l;
    attach = 1'b0;
    lock = 1'b0;
    settle(3);
    rst_n = 1'b1;
    settle(1);
  endtask
  task automatic link_up();
    attach = 1'b1;
    settle(6);
    lock = 1'b1;
    settle(6);
  endtask
  // expected word from current pins and effective enable
  function automatic logic [35:0] exp_word(input logic d);
    logic [31:0] x;
    x = w24 ? {8'h00, b[9:2], g[9:2], r[9:2]} : {u, b, g, r};
    if (!d)
      x = x & `VSL_BLANK_MASK;
    return {1'b0, d, vs, hs, x};
  endfunction
  // inputs held six cycles, well over the two-period enable minimum
  task automatic pix(input logic dd, input logic ee);
    de = dd;
    vs = ~dd;
    hs = dd;
    edge_sel = ee;
    settle(6);
    check(word, exp_word(inv_n ? dd : ~dd));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    r = 10'h3A5;
    g = 10'h1C3;
    b = 10'h2F0;
    u = 2'h2;
    {de, vs, hs, edge_sel, inv_n, error_test_entry, emph, swing} = 8'h18;
    stall = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1], k[0]);
      check(frange, k[1:0]);
      check(w24_o, k[1]);
      check(hold, 1'b1);
      check({train, valid, drop}, 3'b000);
    end
    done("straps");
    lock = 1'b1;
    settle(6);
    check({hold, train}, 2'b10);
    lock = 1'b0;
    attach = 1'b1;
    settle(6);
    check({hold, train}, 2'b01);
    lock = 1'b1;
    settle(6);
    check(train, 1'b0);
    lock = 1'b0;
    settle(6);
    check(train, 1'b1);
    lock = 1'b1;
    settle(6);
    done("link");
    pix(1'b1, 1'b1);
    pix(1'b0, 1'b1);
    do_reset(1'b0, 1'b0);
    link_up();
    pix(1'b1, 1'b1);
    pix(1'b0, 1'b1);
    pix(1'b1, 1'b0);
    // falling-edge capture lands a cycle ahead of rising-edge capture
    de = 1'b0;
    vs = 1'b1;
    hs = 1'b0;
    settle(2);
    check(word, exp_word(1'b0));
    inv_n = 1'b0;
    pix(1'b0, 1'b1);
    pix(1'b1, 1'b1);
    inv_n = 1'b1;
    done("data");
    for (int k = 0; k < 4; k++)
    begin
      emph = k[1];
      swing = k[0];
      settle(3);
      check({emph_o, swing_o}, k[1:0]);
    end
    done("driver");
    // back up the buffer, stop pushes via lost lock, then drain it
    check(drop, 1'b0);
    stall = 1'b1;
    settle(30);
    check(drop, 1'b1);
    lock = 1'b0;
    settle(6);
    stall = 1'b0;
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk);
      if (valid === 1'b1)
        n++;
    end
    check(n, 17);
    check(valid, 1'b0);
    settle(1);
    lock = 1'b1;
    settle(6);
    done("fifo");
    error_test_entry = 1'b1;
    settle(6);
    check({bet_o, train}, 2'b10);
    check(word[35:32], 4'h8);
    prev = word;
    settle(1);
    check(word !== prev, 1'b1);
    error_test_entry = 1'b0;
    settle(8);
    check({bet_o, word[35]}, 2'b00);
    done("bet");
    attach = 1'b0;
    settle(6);
    check({hold, train, bet_o}, 3'b100);
    done("powerdown");
    final_report();
  end
endmodule // testbench
`default_nettype wire

// File: vsl_defs.svh
`ifndef VSL_DEFS_SVH
`define VSL_DEFS_SVH

// clock and stream geometry
`define VSL_CLK_PERIOD_NS 40
`define VSL_FIFO_DEPTH 16
`define VSL_DATA_W 32
`define VSL_WORD_W 36

// stream word field positions
`define VSL_F_HSYNC 32
`define VSL_F_VSYNC 33
`define VSL_F_DE 34
`define VSL_F_KIND 35

// capture vector field positions
`define VSL_C_DE 0
`define VSL_C_HSYNC 1
`define VSL_C_VSYNC 2
`define VSL_C_DATA_LO 3

// bits forwarded as blank payload while data-enable is inactive
`define VSL_BLANK_MASK 32'hC003_0303

// test pattern generator
`define VSL_LFSR_SEED 32'hFFFF_FFFF
`define VSL_LFSR_TAPS 32'h8020_0003

// pixel clock range codes: {width_select, low_freq_select}
`define VSL_RANGE_32_NORM 2'h0
`define VSL_RANGE_32_LOW 2'h1
`define VSL_RANGE_24_NORM 2'h2
`define VSL_RANGE_24_LOW 2'h3

// synchroniser idle level of the pulled-up receiver lines
`define VSL_LINE_IDLE 1'b1

`endif

// File: vsl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module vsl_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_in_valid, // write request
  input wire logic [W-1:0] i_in_data, // write data
  output logic o_in_ready, // space available
  output logic o_out_valid, // output word present
  output logic [W-1:0] o_out_data, // output word
  input wire logic i_out_ready // consumer takes word
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic out_valid_r;
  logic out_valid_nxt;
  logic [W-1:0] out_data_r;
  logic [W-1:0] out_data_nxt;
  logic wr_en;
  logic rd_en;

  //////////////////////////////////////////////////////////////////////////////
  // output stage is a register so downstream timing never sees the array
  always_comb
  begin
    wr_en = i_in_valid && (cnt_r != DEPTH[AW:0]);
    rd_en = (cnt_r != '0) && (!out_valid_r || i_out_ready);
    wr_ptr_nxt = wr_en ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = rd_en ? rd_ptr_r + 1'b1 : rd_ptr_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
    out_valid_nxt = rd_en ? 1'b1 : (i_out_ready ? 1'b0 : out_valid_r);
    out_data_nxt = rd_en ? mem_r[rd_ptr_r] : out_data_r;
    if (!i_rst_n)
    begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      cnt_nxt = '0;
      out_valid_nxt = 1'b0;
      out_data_nxt = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    wr_ptr_r <= wr_ptr_nxt;
    rd_ptr_r <= rd_ptr_nxt;
    cnt_r <= cnt_nxt;
    out_valid_r <= out_valid_nxt;
    out_data_r <= out_data_nxt;
    if (wr_en)
    begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  assign o_in_ready = (cnt_r != DEPTH[AW:0]);
  assign o_out_valid = out_valid_r;
  assign o_out_data = out_data_r;

endmodule // vsl_fifo
`default_nettype wire

// File: vsl_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsl_defs.svh"

//
// Contract
// - width select high: 24-bit, low: 32-bit pixels
// - width and low-freq select pick clock range
// - user bits carried only in 32-bit mode
// - inputs latched on edge chosen by edge select
// - enable high sends pixels, low sends sync
// - blank periods forward designated payload bits
// - enable_invert_n low inverts data-enable first
// - hot-plug high keeps or enters power-down
// - hot-plug low starts training pattern
// - lock low ends training, starts data
// - lock evaluated only while hot-plug low
// - power_down_n low is power-down and reset
// - error_test_entry high selects bit-error test
// - swing and emphasis selects configure driver
// - 32 data plus 3 sync bits per clock
// - power-down holds both serial outputs high
// - bit-error test sends generated pattern
module vsl_link_ctrl
  import vsl_pkg::*;
#(
  parameter int FIFO_DEPTH = `VSL_FIFO_DEPTH
) (
  input wire logic i_core_clk, // pixel clock
  input wire logic i_rst_n, // power_down_n, synchronous, active low
  input wire logic [9:0] i_pix_red, // red component
  input wire logic [9:0] i_pix_green, // green component
  input wire logic [9:0] i_pix_blue, // blue component
  input wire logic [1:0] i_user_bits, // user defined bits
  input wire logic i_de, // data enable
  input wire logic i_vsync, // vertical sync
  input wire logic i_hsync, // horizontal sync
  input wire logic i_width_select, // 1: 24-bit, 0: 32-bit
  input wire logic i_low_freq_select, // 1: low frequency range
  input wire logic i_latch_edge_select, // 1: rising, 0: falling
  input wire logic i_enable_invert_n, // 0: invert data enable
  input wire logic i_error_test_entry, // 1: bit-error test mode
  input wire logic i_emphasis_select, // 1: emphasis enabled
  input wire logic i_swing_select, // 1: high swing
  input wire logic i_hot_plug_n, // receiver present, active low
  input wire logic i_rx_lock_n, // receiver locked, active low
  input wire logic i_word_ready, // serializer takes a word
  output logic o_word_valid, // stream word present
  output logic [`VSL_WORD_W-1:0] o_word, // {kind, de, vsync, hsync, data}
  output logic [1:0] o_freq_range, // selected clock range code
  output logic o_width24, // captured width mode
  output logic o_send_training, // training pattern on lane
  output logic o_bet_active, // test pattern on lane
  output logic o_serial_hold_high, // both serial outputs high
  output logic o_swing_high, // driver high swing
  output logic o_emphasis_en, // driver emphasis on
  output logic o_drop_seen // word lost to a full buffer
);

  localparam int CAP_W = 35;

  logic [CAP_W-1:0] cap_pos_r;
  logic [CAP_W-1:0] cap_pos_nxt;
  logic [CAP_W-1:0] cap_neg_r;
  logic [CAP_W-1:0] cap_neg_nxt;
  logic [CAP_W-1:0] cap_sel;
  logic [CAP_W-1:0] cap_raw;
  logic edge_r;
  logic edge_nxt;
  logic inv_n_r;
  logic inv_n_nxt;
  logic bet_r;
  logic bet_nxt;
  logic width24_r;
  logic width24_nxt;
  logic lowf_r;
  logic lowf_nxt;
  logic hp_s;
  logic lock_s;
  vsl_link_state_t state_r;
  vsl_link_state_t state_nxt;
  logic [31:0] lfsr_r;
  logic [31:0] lfsr_nxt;
  logic de_eff;
  logic [31:0] pix_word;
  logic push_valid;
  logic push_ready;
  logic [`VSL_WORD_W-1:0] push_word;
  logic drop_r;
  logic drop_nxt;
  logic [5:0] cfg_r;
  logic [5:0] cfg_nxt;

  // pack the three colours and user bits into the 32-bit data field
  function automatic logic [31:0] vsl_pack(input logic [31:0] raw, input logic w24);
    logic [31:0] res;
    res = raw;
    if (w24)
      res = {8'h00, raw[29:22], raw[19:12], raw[9:2]};
    return res;
  endfunction

  // galois step of the test pattern generator
  function automatic logic [31:0] vsl_lfsr_step(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ `VSL_LFSR_TAPS) : (s >> 1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input capture on both edges, the edge select picks one of them
  assign cap_raw = {i_user_bits, i_pix_blue, i_pix_green, i_pix_red, i_vsync, i_hsync, i_de};

  always_comb
  begin
    cap_pos_nxt = i_rst_n ? cap_raw : '0;
    cap_neg_nxt = i_rst_n ? cap_raw : '0;
  end

  always_ff @(posedge i_core_clk)
  begin
    cap_pos_r <= cap_pos_nxt;
  end

  // falling-edge copy is only read through the mux, never by itself
  always_ff @(negedge i_core_clk)
  begin
    cap_neg_r <= cap_neg_nxt;
  end

  assign cap_sel = edge_r ? cap_pos_r : cap_neg_r;

  //////////////////////////////////////////////////////////////////////////////
  // mode straps are sampled only while power_down_n is low, so a change needs a toggle
  always_comb
  begin
    edge_nxt = i_latch_edge_select;
    inv_n_nxt = i_enable_invert_n;
    bet_nxt = i_error_test_entry;
    width24_nxt = i_rst_n ? width24_r : i_width_select;
    lowf_nxt = i_rst_n ? lowf_r : i_low_freq_select;
    cfg_nxt = {i_swing_select, i_emphasis_select, width24_r, lowf_r, 2'b00};
    if (!i_rst_n)
    begin
      edge_nxt = 1'b1;
      inv_n_nxt = 1'b1;
      bet_nxt = 1'b0;
      cfg_nxt = '0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    edge_r <= edge_nxt;
    inv_n_r <= inv_n_nxt;
    bet_r <= bet_nxt;
    width24_r <= width24_nxt;
    lowf_r <= lowf_nxt;
    cfg_r <= cfg_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver lines, idle high through pull-ups
  vsl_sync2 #(.RST_VAL(`VSL_LINE_IDLE)) u_sync_hp (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_hot_plug_n),
    .o_sync(hp_s)
  );

  vsl_sync2 #(.RST_VAL(`VSL_LINE_IDLE)) u_sync_lock (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_rx_lock_n),
    .o_sync(lock_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // link state: hot-plug gates everything, lock is looked at only below it
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      VSL_ST_PWRDN:
        if (!hp_s)
          state_nxt = VSL_ST_TRAIN;
      VSL_ST_TRAIN:
        if (hp_s)
          state_nxt = VSL_ST_PWRDN;
        else if (bet_r)
          state_nxt = VSL_ST_BET;
        else if (!lock_s)
          state_nxt = VSL_ST_NORMAL;
      VSL_ST_NORMAL:
        if (hp_s)
          state_nxt = VSL_ST_PWRDN;
        else if (bet_r)
          state_nxt = VSL_ST_BET;
        else if (lock_s)
          state_nxt = VSL_ST_TRAIN;
      VSL_ST_BET:
        if (hp_s)
          state_nxt = VSL_ST_PWRDN;
        else if (!bet_r)
          state_nxt = VSL_ST_TRAIN;
      default:
        state_nxt = VSL_ST_PWRDN;
    endcase
    if (!i_rst_n)
      state_nxt = VSL_ST_PWRDN;
  end

  always_ff @(posedge i_core_clk)
  begin
    state_r <= state_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // stream word: one per clock, 32 data bits and 3 sync bits
  always_comb
  begin
    de_eff = inv_n_r ? cap_sel[`VSL_C_DE] : ~cap_sel[`VSL_C_DE];
    pix_word = vsl_pack(cap_sel[CAP_W-1:`VSL_C_DATA_LO], width24_r);
    push_word = '0;
    push_word[`VSL_F_HSYNC] = cap_sel[`VSL_C_HSYNC];
    push_word[`VSL_F_VSYNC] = cap_sel[`VSL_C_VSYNC];
    push_word[`VSL_F_DE] = de_eff;
    if (state_r == VSL_ST_BET)
      push_word = {1'b1, 3'b000, lfsr_r};
    else if (de_eff)
      push_word[31:0] = pix_word;
    else
      push_word[31:0] = pix_word & `VSL_BLANK_MASK;
    push_valid = (state_r == VSL_ST_NORMAL) || (state_r == VSL_ST_BET);
  end

  //////////////////////////////////////////////////////////////////////////////
  // the pixel source cannot stall, so a full buffer loses the word
  always_comb
  begin
    lfsr_nxt = lfsr_r;
    if ((state_r == VSL_ST_BET) && push_ready)
      lfsr_nxt = vsl_lfsr_step(lfsr_r);
    drop_nxt = drop_r || (push_valid && !push_ready);
    if (!i_rst_n)
    begin
      lfsr_nxt = `VSL_LFSR_SEED;
      drop_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    lfsr_r <= lfsr_nxt;
    drop_r <= drop_nxt;
  end

  vsl_fifo #(.W(`VSL_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_valid),
    .i_in_data(push_word),
    .o_in_ready(push_ready),
    .o_out_valid(o_word_valid),
    .o_out_data(o_word),
    .i_out_ready(i_word_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status outputs straight from flops
  assign o_freq_range = cfg_r[3:2];
  assign o_width24 = cfg_r[3];
  assign o_swing_high = cfg_r[5];
  assign o_emphasis_en = cfg_r[4];
  assign o_send_training = state_r[1];
  assign o_bet_active = state_r[3];
  assign o_serial_hold_high = state_r[0];
  assign o_drop_seen = drop_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_plugged_locked;
    !hp_s && !lock_s && !bet_r;
  endsequence

  sequence s_plugged_unlocked;
    !hp_s && lock_s && !bet_r;
  endsequence

  a_plug_starts_train: assert property (
    (state_r == VSL_ST_PWRDN) && !hp_s |=> (state_r == VSL_ST_TRAIN) && o_send_training)
    else $error("hot-plug low did not start training");

  a_unplug_powers_down: assert property (
    hp_s && (state_r != VSL_ST_PWRDN) |=> o_serial_hold_high && !o_send_training && !o_bet_active)
    else $error("hot-plug high did not reach power-down");

  a_lock_ends_train: assert property (
    (state_r == VSL_ST_TRAIN) ##0 s_plugged_locked |=> (state_r == VSL_ST_NORMAL))
    else $error("lock low did not end training");

  a_lock_gated_plug: assert property (
    hp_s |=> (state_r != VSL_ST_NORMAL))
    else $error("data mode entered with hot-plug released");

  a_relock_fallback: assert property (
    (state_r == VSL_ST_NORMAL) ##0 s_plugged_unlocked |=> (state_r == VSL_ST_TRAIN))
    else $error("lost lock did not return to training");

  a_pwrdn_high_out: assert property (
    (!$past(i_rst_n) || (state_r == VSL_ST_PWRDN)) |-> o_serial_hold_high && !o_send_training && !push_valid)
    else $error("serial outputs not held high in power-down");

  a_user_24bit: assert property (
    push_valid && width24_r && (state_r != VSL_ST_BET) |-> push_word[31:24] == 8'h00)
    else $error("user bits leaked in 24-bit mode");

  a_blank_payload: assert property (
    push_valid && !de_eff && (state_r == VSL_ST_NORMAL)
      |-> (push_word[31:0] & ~`VSL_BLANK_MASK) == 32'h0000_0000)
    else $error("non-payload bits sent during blanking");

  a_bet_pattern: assert property (
    (state_r == VSL_ST_BET) && push_ready |-> push_word[`VSL_F_KIND] ##1 lfsr_r != $past(lfsr_r))
    else $error("test pattern not generated");

  a_driver_cfg: assert property (
    $past(i_rst_n) |-> o_swing_high == $past(i_swing_select) && o_emphasis_en == $past(i_emphasis_select))
    else $error("driver swing not following select");

endmodule // vsl_link_ctrl
`default_nettype wire

// File: vsl_pkg.sv
package vsl_pkg;

  // link control states, one-hot
  typedef enum logic [3:0] {
    VSL_ST_PWRDN = 4'b0001,
    VSL_ST_TRAIN = 4'b0010,
    VSL_ST_NORMAL = 4'b0100,
    VSL_ST_BET = 4'b1000
  } vsl_link_state_t;

endpackage

// File: vsl_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module vsl_rx_model (
  input wire logic i_attach, // receiver active and connected
  input wire logic i_lock, // cdr lock done
  input wire logic i_stall, // serializer busy
  output logic o_hot_plug_n, // resolved open-drain line
  output logic o_rx_lock_n, // resolved open-drain line
  output logic o_word_ready // serializer takes a word
);
  // receiver only pulls low; pull-up gives the high level when released
  assign o_hot_plug_n = i_attach ? 1'b0 : 1'b1;
  assign o_rx_lock_n = i_lock ? 1'b0 : 1'b1;
  // stall is commanded by the bench to back up the buffer
  assign o_word_ready = !i_stall;
endmodule // vsl_rx_model
`default_nettype wire

// File: vsl_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module vsl_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk, // sampling clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_async, // asynchronous level
  output logic o_sync // synchronised level
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_comb
  begin
    meta_nxt = i_rst_n ? i_async : RST_VAL;
    sync_nxt = i_rst_n ? meta_r : RST_VAL;
  end

  always_ff @(posedge i_clk)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign o_sync = sync_r;

endmodule // vsl_sync2
`default_nettype wire
